//--- crc_consts.svh
// Purpose: Constants for the console run control block.
// Assumes: 20 MHz CLK; operator inputs are asynchronous pins.
// Notes: Offsets are byte addresses on the AXI4-Lite slave.
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH
`define CRC_CLK_HZ 20000000
`define CRC_LOAD_REVERT_NS 2000
`define CRC_LOAD_REVERT_CYC ((`CRC_LOAD_REVERT_NS * (`CRC_CLK_HZ / 1000000)) / 1000)
`define CRC_BOOT_ADDR 16'h0140
`define CRC_OFF_CTRL 4'h0
`define CRC_OFF_STAT 4'h4
`define CRC_OFF_CHAN 4'h8
`define CRC_OFF_FAULT 4'hC
`define CRC_CTRL_RESET 32'h0000_0000
`endif

//--- crc_pkg.sv
// Purpose: Types for the console run control block.
// Assumes: Included constants header supplies numbers.
// Notes: Mode order is fixed by the status register layout.
package crc_pkg;
  typedef enum logic [1:0] {CRC_RUN, CRC_PHASE, CRC_ISTEP, CRC_LOAD} crc_mode_e;
  typedef enum logic [1:0] {CRC_IDLE, CRC_ARMED, CRC_FIRED} crc_start_e;
endpackage : crc_pkg

//--- crc_sync_edge.sv
// Purpose: Two-flop synchroniser with rising-edge pulse.
// Assumes: Input is asynchronous to clk.
// Notes: First stage feeds only the second stage.
module crc_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  initial begin
    if (W < 1) $error("crc_sync_edge: W must be positive");
  end
  // Synchronise then remember last level for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign level = s2_r;
  assign rise = s2_r & ~s3_r;
endmodule : crc_sync_edge

//--- crc_console.sv
// Purpose: Start/stop, clear and mode-select logic of the operator console.
// Assumes: Panel switches arrive asynchronously; cpu status strobes are on CLK.
// Notes: Master clear scope depends on the run state at the press.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`include "crc_consts.svh"
module crc_console import crc_pkg::*; #(
  parameter int REVERT_CYC = `CRC_LOAD_REVERT_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SW_START_STEP,
  input wire logic SW_RESTART,
  input wire logic OSC_PULSE,
  input wire logic SW_CHAN_CLEAR,
  input wire logic SW_MASTER_CLEAR,
  input wire logic [3:0] MODE_BUTTON,
  input wire logic [1:0] SEQUENCE_HALT_SELECTOR,
  input wire logic PROG_STOP,
  input wire logic FMT1_READ_END,
  input wire logic MAJOR_SEQ_END,
  input wire logic FETCH_DONE,
  input wire logic VOLT_FAULT_IN,
  input wire logic PROG_FAULT_IN,
  input wire logic PROT_VIOL_IN,
  output logic RUN,
  output logic PROGRAM_RUN_B,
  output logic INSTRUCTION_STEP_MODE,
  output logic PHASE_STEP,
  output logic LOAD_MODE_B,
  output logic FORCE_BOOT,
  output logic [15:0] BOOT_ADDR,
  output logic [3:0] PHASE_PULSE,
  output logic CHAN_CLEAR,
  output logic CHAN_SET,
  output logic MASTER_CLEAR_ALL,
  output logic MASTER_CLEAR_FAULTS,
  output logic VOLT_FAULT,
  output logic PROG_FAULT,
  output logic PROT_FAULT,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam int CW = $clog2(REVERT_CYC + 1);
  initial begin
    if (REVERT_CYC < 1) $error("crc_console: REVERT_CYC must be at least 1");
  end

  // Reset release through two flops
  logic rst_s1_r;
  logic rst_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_r <= rst_s1_r;
    end
  end

  // Panel inputs: synchronised, with one-cycle rising edges
  // Bit 0 is a spare tied low so that pin bits count from one
  logic [11:0] pin_lvl;
  logic [11:0] pin_rise;
  crc_sync_edge #(.W(12)) u_sync (
    .clk(CLK),
    .rst_b(rst_r),
    .din({SEQUENCE_HALT_SELECTOR, MODE_BUTTON, SW_MASTER_CLEAR, SW_CHAN_CLEAR,
          OSC_PULSE, SW_RESTART, SW_START_STEP, 1'b0}),
    .level(pin_lvl),
    .rise(pin_rise)
  );
  wire start_rise = pin_rise[1];
  wire restart_lvl = pin_lvl[2];
  wire osc_rise = pin_rise[3];
  wire chan_clr_req = pin_rise[4];
  wire mclr_req = pin_rise[5];
  wire [3:0] btn_rise = pin_rise[9:6];
  wire sel_stop = pin_lvl[10];
  wire sel_seq = pin_lvl[11];

  // AXI4-Lite control register: bit0 soft start, bit1 soft stop (self-clearing)
  logic soft_start_r;
  logic soft_stop_r;

  // Mode selection
  crc_mode_e mode_r;
  crc_mode_e mode_nxt;
  logic run_r;
  logic [CW-1:0] revert_cnt_r;
  logic boot_r;
  logic [1:0] phase_r;
  logic [3:0] phase_pulse_r;
  logic volt_r;
  logic prog_r;
  logic prot_r;
  logic chan_clr_r;
  logic mclr_all_r;
  logic mclr_flt_r;

  // Mode decode feeds several outputs, so it lives in one place
  function automatic logic [3:0] mode_hot(input crc_mode_e m);
    mode_hot = 4'h0;
    case (m)
      CRC_RUN: mode_hot = 4'h1;
      CRC_PHASE: mode_hot = 4'h2;
      CRC_ISTEP: mode_hot = 4'h4;
      CRC_LOAD: mode_hot = 4'h8;
      default: mode_hot = 4'h0;
    endcase
  endfunction : mode_hot
  // One-hot view {load, istep, phase, run}; the encoded register cannot hold two modes
  wire [3:0] mode_oh = mode_hot(mode_r);

  // Single start per press or pulse; restart must be held while the pulse arrives
  wire start_req = start_rise | (restart_lvl & osc_rise) | soft_start_r;
  wire phase_mode = (mode_r == CRC_PHASE);
  // A start while running is dropped, not queued: one start per actuation
  wire go_run = start_req & ~phase_mode & ~run_r;
  wire step_phase = start_req & phase_mode;
  wire stop_run = (mode_r == CRC_RUN) & (PROG_STOP | sel_stop);
  wire stop_istep = (mode_r == CRC_ISTEP) &
                    ((~sel_seq & ~sel_stop & FMT1_READ_END) | (sel_seq & MAJOR_SEQ_END));
  wire stop_any = stop_run | stop_istep | soft_stop_r;
  // Revert is judged on the counter, so a load run lasts a fixed number of cycles
  wire revert_done = (mode_r == CRC_LOAD) & run_r & (revert_cnt_r == CW'(REVERT_CYC));
  // Clear scope follows the run flag and phase mode at the press: a running or phase-stepping machine keeps all but its fault flags
  wire idle_clear = mclr_req & ~run_r & ~phase_mode;

  // Button decode: the lowest pressed button wins so one mode results
  always_comb begin
    mode_nxt = mode_r;
    if (btn_rise[0]) mode_nxt = CRC_RUN;
    else if (btn_rise[1]) mode_nxt = CRC_PHASE;
    else if (btn_rise[2]) mode_nxt = CRC_ISTEP;
    else if (btn_rise[3]) mode_nxt = CRC_LOAD;
    else if (revert_done) mode_nxt = CRC_RUN;
    if (idle_clear) mode_nxt = CRC_RUN;
  end

  // Mode register holds one encoded value so only one mode can ever be active
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) mode_r <= CRC_RUN;
    else mode_r <= mode_nxt;
  end

  // Run flag: set on start, cleared by any stop or a full master clear
  // Stop outranks start, so a stop and a start together leave the machine halted
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) run_r <= 1'b0;
    else if (stop_any | idle_clear) run_r <= 1'b0;
    else if (go_run) run_r <= 1'b1;
  end

  // Load mode timer counts run cycles toward the revert point
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) revert_cnt_r <= '0;
    else if (mode_r != CRC_LOAD || !run_r) revert_cnt_r <= '0;
    else if (!revert_done) revert_cnt_r <= revert_cnt_r + CW'(1);
  end

  // Boot fetch forcing: raised on load start, dropped once fetched
  // Leaving load mode also drops it, so a missing fetch acknowledge cannot pin it high
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) boot_r <= 1'b0;
    else if (go_run && mode_r == CRC_LOAD) boot_r <= 1'b1;
    else if (FETCH_DONE || mode_r != CRC_LOAD) boot_r <= 1'b0;
  end

  // Phase step: emit one phase pulse per press, then advance
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      phase_r <= 2'h0;
      phase_pulse_r <= 4'h0;
    end else begin
      phase_pulse_r <= step_phase ? (4'h1 << phase_r) : 4'h0;
      if (step_phase) phase_r <= phase_r + 2'h1;
      else if (idle_clear) phase_r <= 2'h0;
    end
  end

  // Fault flags: set wins over master clear
  // Losing a fault that lands with the clear would hide the event from software
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      volt_r <= 1'b0;
      prog_r <= 1'b0;
      prot_r <= 1'b0;
    end else begin
      volt_r <= VOLT_FAULT_IN | (volt_r & ~mclr_req);
      prog_r <= PROG_FAULT_IN | (prog_r & ~mclr_req);
      prot_r <= PROT_VIOL_IN | (prot_r & ~mclr_req);
    end
  end

  // Clear strobes registered to keep outputs glitch-free
  // Channel clear and set share one strobe because both groups act on one press
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      chan_clr_r <= 1'b0;
      mclr_all_r <= 1'b0;
      mclr_flt_r <= 1'b0;
    end else begin
      chan_clr_r <= chan_clr_req | idle_clear;
      mclr_all_r <= idle_clear;
      mclr_flt_r <= mclr_req;
    end
  end

  assign RUN = run_r;
  assign PROGRAM_RUN_B = ~mode_oh[0];
  assign INSTRUCTION_STEP_MODE = mode_oh[2];
  assign PHASE_STEP = mode_oh[1];
  assign LOAD_MODE_B = ~mode_oh[3];
  assign FORCE_BOOT = boot_r;
  assign BOOT_ADDR = `CRC_BOOT_ADDR;
  assign PHASE_PULSE = phase_pulse_r;
  assign CHAN_CLEAR = chan_clr_r;
  assign CHAN_SET = chan_clr_r;
  assign MASTER_CLEAR_ALL = mclr_all_r;
  assign MASTER_CLEAR_FAULTS = mclr_flt_r;
  assign VOLT_FAULT = volt_r;
  assign PROG_FAULT = prog_r;
  assign PROT_FAULT = prot_r;

  // AXI4-Lite slave: address and data taken in either order, one write and read
  logic aw_ok_r;
  logic w_ok_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wstrb0_r;
  // Address map shared by the write and read decoders; one bit per register
  function automatic logic [3:0] reg_hit(input logic [3:0] a);
    reg_hit = 4'h0;
    case (a)
      `CRC_OFF_CTRL: reg_hit = 4'h1;
      `CRC_OFF_STAT: reg_hit = 4'h2;
      `CRC_OFF_CHAN: reg_hit = 4'h4;
      `CRC_OFF_FAULT: reg_hit = 4'h8;
      default: reg_hit = 4'h0;
    endcase
  endfunction : reg_hit
  wire [3:0] wr_hit = reg_hit(awaddr_r);
  wire [3:0] rd_hit = reg_hit(S_AXI_ARADDR);
  wire aw_take = S_AXI_AWVALID & ~aw_ok_r & ~bvalid_r;
  wire w_take = S_AXI_WVALID & ~w_ok_r & ~bvalid_r;
  wire wr_go = aw_ok_r & w_ok_r;
  wire wr_ctrl = wr_go & wr_hit[0] & wstrb0_r;
  wire wr_known = wr_hit[0];
  wire ar_take = S_AXI_ARVALID & ~rvalid_r;
  // Status words are built from live flags, so a read returns the state at its address edge
  wire [31:0] stat_word = {27'h0, run_r, 2'h0, mode_r};
  wire [31:0] chan_word = {30'h0, phase_r};
  wire [31:0] flt_word = {29'h0, prot_r, prog_r, volt_r};
  wire rd_known = |rd_hit;
  wire [31:0] rd_word = rd_hit[1] ? stat_word :
                        rd_hit[2] ? chan_word :
                        rd_hit[3] ? flt_word : `CRC_CTRL_RESET;

  // Write path
  // The strobe is kept with the data, since the master may change it once W is taken
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_ok_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb0_r <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? 2'h0 : 2'h2;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Soft start and stop are one-cycle pulses from a control write
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      soft_start_r <= 1'b0;
      soft_stop_r <= 1'b0;
    end else begin
      soft_start_r <= wr_ctrl & wdata_r[0];
      soft_stop_r <= wr_ctrl & wdata_r[1];
    end
  end

  // Read path; unmapped addresses answer SLVERR with zero data
  // One read at a time, so the address decode can stay combinational up to the take
  always_ff @(posedge CLK or negedge rst_r) begin
    if (!rst_r) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_known ? 2'h0 : 2'h2;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Ready stays low until the internal reset lets go, so no transfer is swallowed
  assign S_AXI_AWREADY = rst_r & ~aw_ok_r & ~bvalid_r;
  assign S_AXI_WREADY = rst_r & ~w_ok_r & ~bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = rst_r & ~rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
endmodule : crc_console

//--- crc_console_assertions.sv
// Purpose: Concurrent checks on the console run control ports.
// Assumes: Bound to every crc_console instance.
// Notes: All checks sit on CLK and pause while RST_B is low.
module crc_console_chk (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PROG_STOP,
  input wire logic FMT1_READ_END,
  input wire logic MAJOR_SEQ_END,
  input wire logic [1:0] SEQUENCE_HALT_SELECTOR,
  input wire logic RUN,
  input wire logic PROGRAM_RUN_B,
  input wire logic INSTRUCTION_STEP_MODE,
  input wire logic PHASE_STEP,
  input wire logic LOAD_MODE_B,
  input wire logic FORCE_BOOT,
  input wire logic [15:0] BOOT_ADDR,
  input wire logic [3:0] PHASE_PULSE,
  input wire logic CHAN_CLEAR,
  input wire logic CHAN_SET,
  input wire logic MASTER_CLEAR_ALL
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Mode outputs mix polarities, so decode both back to one-hot
  chk_one_mode: assert property ($onehot({~PROGRAM_RUN_B, PHASE_STEP,
    INSTRUCTION_STEP_MODE, ~LOAD_MODE_B}))
    else $error("mode outputs not one-hot");
  // The selector is a pin: the design acts on it two clocks after the edge that sees it
  chk_run_stop: assert property (RUN && !PROGRAM_RUN_B
    && (PROG_STOP || $past(SEQUENCE_HALT_SELECTOR[0], 2)) |=> !RUN)
    else $error("run mode stop ignored");
  chk_fmt1_stop: assert property (RUN && INSTRUCTION_STEP_MODE
    && $past(SEQUENCE_HALT_SELECTOR, 2) == 2'h0 && FMT1_READ_END |=> !RUN)
    else $error("first-format stop ignored");
  chk_major_stop: assert property (RUN && INSTRUCTION_STEP_MODE
    && $past(SEQUENCE_HALT_SELECTOR, 2) == 2'h2 && MAJOR_SEQ_END |=> !RUN)
    else $error("major sequence stop ignored");
  chk_chan_pair: assert property (CHAN_CLEAR == CHAN_SET)
    else $error("channel clear and set differ");
  chk_clear_width: assert property (CHAN_CLEAR |=> !CHAN_CLEAR)
    else $error("channel clear longer than one cycle");
  chk_phase_pulse: assert property ((PHASE_PULSE != 4'h0)
    |-> $onehot(PHASE_PULSE) ##1 (PHASE_PULSE == 4'h0))
    else $error("phase pulse not single one-hot");
  chk_boot_addr: assert property (FORCE_BOOT |-> BOOT_ADDR == 16'h0140)
    else $error("boot address wrong");
  chk_full_clear: assert property (MASTER_CLEAR_ALL |-> !RUN && !PHASE_STEP)
    else $error("full clear while running or phase stepping");
  cover property ($rose(RUN));
  cover property ($fell(LOAD_MODE_B));
  cover property (MASTER_CLEAR_ALL);
endmodule : crc_console_chk

bind crc_console crc_console_chk crc_console_chk_inst (.*);

//--- crc_panel_model.sv
// Purpose: Operator panel model driving the console switches.
// Assumes: Presses are levels held many clocks, as a hand would.
// Notes: Restart oscillator runs free with a 64-clock period.
module crc_panel_model (
  input wire logic CLK,
  output logic SW_START_STEP,
  output logic SW_RESTART,
  output logic OSC_PULSE,
  output logic SW_CHAN_CLEAR,
  output logic SW_MASTER_CLEAR,
  output logic [3:0] MODE_BUTTON,
  output logic [1:0] SEQUENCE_HALT_SELECTOR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sw_r = 8'h00;
  logic [5:0] osc_r = 6'h00;
  initial SEQUENCE_HALT_SELECTOR = 2'h0;
  // Bits: 0 start, 1 restart, 2 channel clear, 3 master clear, 4-7 modes
  assign {MODE_BUTTON, SW_MASTER_CLEAR, SW_CHAN_CLEAR, SW_RESTART, SW_START_STEP} = sw_r;
  // Pulse stays high 16 clocks, so one pulse spans many edges
  assign OSC_PULSE = &osc_r[5:4];
  always @(posedge CLK) osc_r <= osc_r + 6'h01;
  // Hold a switch h clocks, then rest long enough for sync to drain
  task automatic press(input int b, input int h);
    @(posedge CLK);
    sw_r[b] <= 1'b1;
    repeat (h) @(posedge CLK);
    sw_r[b] <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask : press
  task automatic set_sel(input logic [1:0] v);
    @(posedge CLK);
    SEQUENCE_HALT_SELECTOR <= v;
    repeat (4) @(posedge CLK);
  endtask : set_sel
endmodule : crc_panel_model

//--- tb_top.sv
// Purpose: Self-checking bench for crc_console.
// Assumes: REVERT_CYC shortened to 4 clocks.
// Notes: Panel switches come from the panel model, cpu strobes from here.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic SW_START_STEP, SW_RESTART, OSC_PULSE, SW_CHAN_CLEAR, SW_MASTER_CLEAR;
  logic [3:0] MODE_BUTTON;
  logic [1:0] SEQUENCE_HALT_SELECTOR;
  logic PROG_STOP, FMT1_READ_END, MAJOR_SEQ_END, FETCH_DONE;
  logic VOLT_FAULT_IN, PROG_FAULT_IN, PROT_VIOL_IN;
  logic RUN, PROGRAM_RUN_B, INSTRUCTION_STEP_MODE, PHASE_STEP, LOAD_MODE_B, FORCE_BOOT;
  logic [15:0] BOOT_ADDR;
  logic [3:0] PHASE_PULSE;
  logic CHAN_CLEAR, CHAN_SET, MASTER_CLEAR_ALL, MASTER_CLEAR_FAULTS;
  logic VOLT_FAULT, PROG_FAULT, PROT_FAULT;
  logic [3:0] S_AXI_AWADDR = 4'h0;
  logic [3:0] S_AXI_ARADDR = 4'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [31:0] S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [6:0] cpu_r = 7'h00;
  int failures = 0;
  int comparisons = 0;
  int n_ph = 0;
  int n_mca = 0;
  int n_cc = 0;
  int n_mcf = 0;
  // Strobe bits: 0 stop, 1 fmt1 end, 2 major end, 3 fetch, 4-6 faults
  assign {PROT_VIOL_IN, PROG_FAULT_IN, VOLT_FAULT_IN, FETCH_DONE} = cpu_r[6:3];
  assign {MAJOR_SEQ_END, FMT1_READ_END, PROG_STOP} = cpu_r[2:0];
  crc_console #(.REVERT_CYC(4)) crc_console_inst (.*);
  crc_panel_model crc_panel_model_inst (.*);
  initial forever #25 CLK = ~CLK;
  // Counted on the falling edge, clear of register updates
  always @(negedge CLK) begin
    n_ph += (PHASE_PULSE != 4'h0);
    n_mca += MASTER_CLEAR_ALL;
    n_cc += CHAN_CLEAR;
    n_mcf += MASTER_CLEAR_FAULTS;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic press(input int b, input int h);
    crc_panel_model_inst.press(b, h);
  endtask : press
  task automatic pulse(input int i);
    @(posedge CLK);
    cpu_r[i] <= 1'b1;
    @(posedge CLK);
    cpu_r[i] <= 1'b0;
    @(posedge CLK);
  endtask : pulse
  // Handshakes are judged at the falling edge, where ready and valid are settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    @(posedge CLK);
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    b = 1'b0;
    while (!b) begin
      @(negedge CLK);
      aw = S_AXI_AWVALID & S_AXI_AWREADY;
      w = S_AXI_WVALID & S_AXI_WREADY;
      b = S_AXI_BVALID === 1'b1;
      if (b) chk("bresp", 32'(er), 32'(S_AXI_BRESP));
      @(posedge CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input string nm);
    logic ar, r;
    @(posedge CLK);
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    S_AXI_ARADDR <= a;
    r = 1'b0;
    while (!r) begin
      @(negedge CLK);
      ar = S_AXI_ARVALID & S_AXI_ARREADY;
      r = S_AXI_RVALID === 1'b1;
      if (r) chk(nm, ed, S_AXI_RDATA);
      if (r) chk("rresp", 32'h0, 32'(S_AXI_RRESP));
      @(posedge CLK);
      if (ar) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    #500000;
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (6) @(posedge CLK);
    axi_rd(4'h4, 32'h0, "stat");
    axi_wr(4'h4, 32'h1, 2'h2);
    // Switch still held after a stop must not start again
    fork
      press(0, 20);
      begin repeat (8) @(posedge CLK); pulse(0); end
    join
    chk("run", 32'h0, 32'(RUN));
    press(0, 4);
    chk("run", 32'h1, 32'(RUN));
    crc_panel_model_inst.set_sel(2'h1);
    chk("run", 32'h0, 32'(RUN));
    crc_panel_model_inst.set_sel(2'h0);
    press(1, 70);
    axi_rd(4'h4, 32'h10, "stat");
    axi_wr(4'h0, 32'h2, 2'h0);
    chk("run", 32'h0, 32'(RUN));
    for (int i = 4; i < 7; i++) pulse(i);
    chk("flags", 32'h7, 32'({PROT_FAULT, PROG_FAULT, VOLT_FAULT}));
    axi_rd(4'hC, 32'h7, "fault");
    axi_wr(4'h0, 32'h1, 2'h0);
    press(3, 6);
    axi_rd(4'hC, 32'h0, "fault");
    chk("run", 32'h1, 32'(RUN));
    chk("mca", 32'h0, n_mca);
    chk("mcf", 32'h1, n_mcf);
    pulse(0);
    pulse(4);
    press(3, 6);
    axi_rd(4'hC, 32'h0, "fault");
    chk("mca", 32'h1, n_mca);
    chk("mcf", 32'h2, n_mcf);
    press(2, 6);
    chk("cc", 32'h2, n_cc);
    for (int i = 0; i < 4; i++) begin
      press(4 + i, 6);
      axi_rd(4'h4, 32'(i), "stat");
      chk("modes", 32'({i != 0, i == 1, i == 2, i != 3}),
        32'({PROGRAM_RUN_B, PHASE_STEP, INSTRUCTION_STEP_MODE, LOAD_MODE_B}));
    end
    // Boot forcing stands only until the fetch or the revert, so judge it just after start
    fork
      press(0, 6);
      begin
        @(posedge RUN);
        @(negedge CLK);
        chk("boot", 32'h0140, 32'(FORCE_BOOT ? BOOT_ADDR : 16'h0));
        chk("load", 32'h0, 32'(LOAD_MODE_B));
        pulse(3);
        chk("force", 32'h0, 32'(FORCE_BOOT));
      end
    join
    chk("revert", 32'h1, 32'({PROGRAM_RUN_B, LOAD_MODE_B}));
    pulse(0);
    press(6, 6);
    press(0, 6);
    pulse(2);
    chk("run", 32'h1, 32'(RUN));
    pulse(1);
    chk("run", 32'h0, 32'(RUN));
    crc_panel_model_inst.set_sel(2'h2);
    press(0, 6);
    chk("run", 32'h1, 32'(RUN));
    pulse(2);
    chk("run", 32'h0, 32'(RUN));
    crc_panel_model_inst.set_sel(2'h0);
    press(5, 6);
    for (int k = 1; k < 3; k++) begin
      press(0, 6);
      axi_rd(4'h8, 32'(k), "phase");
    end
    chk("pulses", 32'h2, n_ph);
    chk("run", 32'h0, 32'(RUN));
    final_report();
  end
endmodule : tb_top
